// ===== src/dso_defs.vh
// Constants for the drive status output generator.
// Assumes a 40 MHz core clock; included by the design files.
`ifndef DSO_DEFS_VH
`define DSO_DEFS_VH
// ****************************************************************
// Bus register map (byte addresses)
// ****************************************************************
`define DSO_A_SEL_A 8'h00
`define DSO_A_SEL_B 8'h04
`define DSO_A_SEL_C 8'h08
`define DSO_A_BAND 8'h0c
`define DSO_A_LVL_FWD 8'h10
`define DSO_A_LVL_REV 8'h14
`define DSO_A_HYST 8'h18
`define DSO_A_STATUS 8'h1c
`define DSO_A_LOCK 8'h20
// ****************************************************************
// Reset values
// ****************************************************************
`define DSO_RST_SEL_A 8'h00
`define DSO_RST_SEL_B 8'h0b
`define DSO_RST_SEL_C 8'h63
`define DSO_RST_BAND 7'h0a
`define DSO_RST_LVL 14'h00b4
`define DSO_RST_LVL_REV 14'h270f
`define DSO_RST_HYST 8'h0f
`define DSO_RST_LOCK 16'h0000
// ****************************************************************
// Function codes and limits
// ****************************************************************
`define DSO_NEG_BASE 8'h64
`define DSO_CODE_MAX 8'hc7
`define DSO_F_RUN 7'h00
`define DSO_F_SU 7'h01
`define DSO_F_FU 7'h04
`define DSO_F_RY 7'h0b
`define DSO_F_RY2 7'h21
`define DSO_F_RY3 7'h25
`define DSO_F_Y91 7'h5b
`define DSO_F_ALM 7'h63
`define DSO_REV_OFF 14'h270f
`define DSO_BAND_MAX 7'h64
`define DSO_HYST_MAX 8'h96
`define DSO_MIN_RUN 14'h0001
`define DSO_PCT_FULL 21'h000064
// ****************************************************************
// Timing
// ****************************************************************
`define DSO_MS_CYC 16'h9c40
`define DSO_DELAY_W 7
`define DSO_DELAY_CNT 7'h64
`endif

// ===== src/dso_timer.v
// Millisecond delay timer for the drive status output generator.
// Assumes the core clock of the defs header and a synchronous reset.
`timescale 1ns/1ps
`include "dso_defs.vh"
module dso_timer
(
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire i_arm,
  input wire [15:0] i_extra_ms,
  output reg o_done
);
  reg [15:0] tick;
  reg [16:0] ms;
  wire [16:0] target;
  assign target = {1'b0, i_extra_ms} + {10'h000, `DSO_DELAY_CNT};
  // ****************************************************************
  // Counts whole milliseconds while armed; disarm clears at once
  // ****************************************************************
  always @(posedge I_CORE_CLK)
  begin
    if (I_RST || !i_arm)
    begin
      tick <= 16'h0000;
      ms <= 17'h00000;
      o_done <= 1'b0;
    end
    else if (ms >= target)
    begin
      o_done <= 1'b1;
    end
    else if (tick == `DSO_MS_CYC - 16'h0001)
    begin
      tick <= 16'h0000;
      ms <= ms + 17'h00001;
    end
    else
    begin
      tick <= tick + 16'h0001;
    end
  end
endmodule // dso_timer

// ===== src/dso_top.v
// Drive status output generator: status flags routed to three terminals.
// Assumes drive state inputs synchronous to I_CORE_CLK; AHB-Lite slave.
//
// Behaviour
// - Codes 0-99 make the terminal conduct when active; 100-199 invert.
// - One function may drive any number of terminals independently.
// - Ready flag high when ready or running, low in output shutoff.
// - Running flag high at 1 r/min or more, low in stop or braking.
// - Both pre-excitation ready flags high while pre-excitation lasts.
// - Brake-interlocked ready flag low during brake interlock; other stays.
// - Pre-excitation ready flags rise 100 ms after their condition; under DC brake the code raises them at once.
// - Shutoff, faults included, forces ready and running flags low.
// - Decode codes 11/111, 33/133, 37/137 and 0/100.
// - PM start: running flag after brake interlock time plus 100 ms.
// - Fault flag on codes 99/199; relay terminal defaults to it.
// - Internal fault flag from internal or wiring trips, codes 91/191.
// - Ground fault shown as acceleration overcurrent still flags internal.
// - At-speed flag inside percent band around set speed, default 10.
// - Decode codes 1/101 for the at-speed flag.
// - Threshold flag at or above detect level, default 180 r/min.
// - Reverse level used for reverse unless it holds 9999.
// - Decode codes 4/104 for the threshold flag.
// - Speed hysteresis on both speed flags, default 15, range 0-150.
// - Speed flags held low during DC injection braking.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dso_defs.vh"
module dso_top
(
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire I_HSEL,
  input wire [31:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [2:0] I_HSIZE,
  input wire [31:0] I_HWDATA,
  input wire I_HREADY,
  output reg [31:0] O_HRDATA,
  output reg O_HREADYOUT,
  output reg O_HRESP,
  input wire I_MAIN_POWER_OK,
  input wire I_OUTPUT_SHUTOFF_IN,
  input wire I_RUNNING,
  input wire I_ZERO_SPEED_CTRL,
  input wire I_SERVO_LOCK,
  input wire I_DC_BRAKE,
  input wire I_PREEXCITE_CMD_IN,
  input wire I_BRAKE_OPEN_REQUEST,
  input wire I_PM_MODE,
  input wire I_FORWARD_START_IN,
  input wire I_REVERSE_START_IN,
  input wire I_FAULT,
  input wire I_GROUND_FAULT_TRIP,
  input wire I_ACCEL_OVERCURRENT_TRIP,
  input wire I_BRAKE_TRANSISTOR_TRIP,
  input wire I_PHASE_LOSS_TRIP,
  input wire I_PARAM_STORE_TRIP,
  input wire I_PROCESSOR_TRIP,
  input wire I_INRUSH_CIRCUIT_TRIP,
  input wire [13:0] I_SPEED,
  input wire I_SPEED_REVERSE,
  input wire [13:0] I_SET_SPEED,
  output reg O_TERMINAL_A,
  output reg O_TERMINAL_B,
  output reg O_TERMINAL_C,
  output reg [7:0] O_FLAGS
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] terminal_function_sel_a;
  reg [7:0] terminal_function_sel_b;
  reg [7:0] terminal_function_sel_c;
  reg [6:0] at_speed_band_pct;
  reg [13:0] speed_detect_level;
  reg [13:0] reverse_speed_detect_level;
  reg [7:0] speed_detect_hysteresis;
  reg [15:0] brake_interlock_time;
  reg dph_valid;
  reg dph_write;
  reg [7:0] dph_addr;
  reg drive_ready_out;
  reg preexcite_ready_out;
  reg preexcite_ready_brake_out;
  reg motion_active_out;
  reg fault_out;
  reg internal_fault_out;
  reg at_speed_out;
  reg speed_threshold_out;
  reg power_seen;
  reg pm_start_hold;
  wire ap_valid;
  wire shutoff;
  wire preexcite_cond;
  wire delay_done;
  wire pm_done;
  wire run_raw;
  wire [13:0] level;
  wire [20:0] band_full;
  wire [14:0] band;
  wire [14:0] lo_edge;
  wire [14:0] hi_edge;
  wire [14:0] fu_clear;
  wire [14:0] su_clear;
  wire [15:0] extra_zero;
  wire [7:0] flags;
  // ****************************************************************
  // Functions
  // ****************************************************************
  // Terminal level from code and flag vector; illegal codes stay off
  function term_level;
    input [7:0] code;
    input [7:0] f;
    reg neg;
    reg [7:0] base;
    reg [6:0] fn;
    reg act;
    reg known;
    begin
      neg = (code >= `DSO_NEG_BASE);
      base = neg ? code - `DSO_NEG_BASE : code;
      fn = base[6:0];
      known = 1'b1;
      case (fn)
        `DSO_F_RUN: act = f[3];
        `DSO_F_SU: act = f[6];
        `DSO_F_FU: act = f[7];
        `DSO_F_RY: act = f[0];
        `DSO_F_RY2: act = f[1];
        `DSO_F_RY3: act = f[2];
        `DSO_F_Y91: act = f[5];
        `DSO_F_ALM: act = f[4];
        default:
        begin
          act = 1'b0;
          known = 1'b0;
        end
      endcase
      // Unknown codes stay off in both polarities
      if (code > `DSO_CODE_MAX || !known)
        term_level = 1'b0;
      else
        term_level = neg ? ~act : act;
    end
  endfunction
  // Saturating subtraction of the hysteresis width
  function [14:0] sat_sub;
    input [14:0] a;
    input [7:0] b;
    begin
      sat_sub = (a > {7'h00, b}) ? a - {7'h00, b} : 15'h0000;
    end
  endfunction
  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ****************************************************************
  assign ap_valid = I_HSEL && I_HTRANS[1] && I_HREADY;
  always @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= 8'h00;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      O_HRDATA <= 32'h00000000;
    end
    else
    begin
      dph_valid <= ap_valid;
      dph_write <= I_HWRITE;
      dph_addr <= I_HADDR[7:0];
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      if (ap_valid && !I_HWRITE)
      begin
        case (I_HADDR[7:0])
          `DSO_A_SEL_A: O_HRDATA <= {24'h000000, terminal_function_sel_a};
          `DSO_A_SEL_B: O_HRDATA <= {24'h000000, terminal_function_sel_b};
          `DSO_A_SEL_C: O_HRDATA <= {24'h000000, terminal_function_sel_c};
          `DSO_A_BAND: O_HRDATA <= {25'h0000000, at_speed_band_pct};
          `DSO_A_LVL_FWD: O_HRDATA <= {18'h00000, speed_detect_level};
          `DSO_A_LVL_REV: O_HRDATA <= {18'h00000, reverse_speed_detect_level};
          `DSO_A_HYST: O_HRDATA <= {24'h000000, speed_detect_hysteresis};
          `DSO_A_STATUS: O_HRDATA <= {24'h000000, flags};
          `DSO_A_LOCK: O_HRDATA <= {16'h0000, brake_interlock_time};
          default: O_HRDATA <= 32'h00000000;
        endcase
      end
    end
  end
  // Out-of-range band and hysteresis writes are clamped to their limits
  always @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      terminal_function_sel_a <= `DSO_RST_SEL_A;
      terminal_function_sel_b <= `DSO_RST_SEL_B;
      terminal_function_sel_c <= `DSO_RST_SEL_C;
      at_speed_band_pct <= `DSO_RST_BAND;
      speed_detect_level <= `DSO_RST_LVL;
      reverse_speed_detect_level <= `DSO_RST_LVL_REV;
      speed_detect_hysteresis <= `DSO_RST_HYST;
      brake_interlock_time <= `DSO_RST_LOCK;
    end
    else if (dph_valid && dph_write)
    begin
      case (dph_addr)
        `DSO_A_SEL_A: terminal_function_sel_a <= I_HWDATA[7:0];
        `DSO_A_SEL_B: terminal_function_sel_b <= I_HWDATA[7:0];
        `DSO_A_SEL_C: terminal_function_sel_c <= I_HWDATA[7:0];
        `DSO_A_BAND: at_speed_band_pct <= (I_HWDATA[6:0] > `DSO_BAND_MAX ||
          I_HWDATA[31:7] != 25'h0000000) ? `DSO_BAND_MAX : I_HWDATA[6:0];
        `DSO_A_LVL_FWD: speed_detect_level <= I_HWDATA[13:0];
        `DSO_A_LVL_REV: reverse_speed_detect_level <= I_HWDATA[13:0];
        `DSO_A_HYST: speed_detect_hysteresis <= (I_HWDATA[7:0] >
          `DSO_HYST_MAX || I_HWDATA[31:8] != 24'h000000) ?
          `DSO_HYST_MAX : I_HWDATA[7:0];
        `DSO_A_LOCK: brake_interlock_time <= I_HWDATA[15:0];
        default: terminal_function_sel_a <= terminal_function_sel_a;
      endcase
    end
  end
  // ****************************************************************
  // Drive state flags
  // ****************************************************************
  assign shutoff = I_OUTPUT_SHUTOFF_IN || I_FAULT || !I_MAIN_POWER_OK;
  assign preexcite_cond = !shutoff && (I_RUNNING || I_PREEXCITE_CMD_IN);
  assign extra_zero = 16'h0000;
  // Delay applies to operation and commanded pre-excitation only
  dso_timer u_preexcite_delay
  (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RST(I_RST),
    .i_arm(preexcite_cond),
    .i_extra_ms(extra_zero),
    .o_done(delay_done)
  );
  // PM start waits for brake interlock and pole detection
  dso_timer u_pm_delay
  (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RST(I_RST),
    .i_arm(pm_start_hold),
    .i_extra_ms(brake_interlock_time),
    .o_done(pm_done)
  );
  assign run_raw = I_RUNNING && !I_ZERO_SPEED_CTRL && !I_SERVO_LOCK &&
    !I_DC_BRAKE && (I_SPEED >= `DSO_MIN_RUN);
  always @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      power_seen <= 1'b0;
      pm_start_hold <= 1'b0;
      drive_ready_out <= 1'b0;
      preexcite_ready_out <= 1'b0;
      preexcite_ready_brake_out <= 1'b0;
      motion_active_out <= 1'b0;
      fault_out <= 1'b0;
      internal_fault_out <= 1'b0;
    end
    else
    begin
      // Supply must return with no fault before ready is released
      power_seen <= I_MAIN_POWER_OK && (power_seen || !I_FAULT);
      drive_ready_out <= power_seen && !shutoff;
      // DC brake pre-excitation is immediate; others wait 100 ms
      preexcite_ready_out <= !shutoff &&
        (delay_done || I_DC_BRAKE);
      preexcite_ready_brake_out <= !shutoff && !I_BRAKE_OPEN_REQUEST &&
        (delay_done || I_DC_BRAKE);
      pm_start_hold <= I_PM_MODE && !shutoff &&
        (I_FORWARD_START_IN || I_REVERSE_START_IN);
      motion_active_out <= !shutoff && run_raw &&
        (!I_PM_MODE || pm_done);
      fault_out <= I_FAULT;
      internal_fault_out <= I_BRAKE_TRANSISTOR_TRIP || I_GROUND_FAULT_TRIP ||
        I_PHASE_LOSS_TRIP || I_PARAM_STORE_TRIP || I_PROCESSOR_TRIP ||
        I_INRUSH_CIRCUIT_TRIP || I_ACCEL_OVERCURRENT_TRIP;
    end
  end
  // ****************************************************************
  // Speed detection with hysteresis
  // ****************************************************************
  assign level = (I_SPEED_REVERSE &&
    reverse_speed_detect_level != `DSO_REV_OFF) ?
    reverse_speed_detect_level : speed_detect_level;
  // Band in r/min: set speed times percent over 100, truncated
  assign band_full = ({7'h00, I_SET_SPEED} * {14'h0000, at_speed_band_pct})
    / `DSO_PCT_FULL;
  assign band = band_full[14:0];
  assign lo_edge = ({1'b0, I_SET_SPEED} > band) ?
    {1'b0, I_SET_SPEED} - band : 15'h0000;
  assign hi_edge = {1'b0, I_SET_SPEED} + band;
  assign fu_clear = sat_sub({1'b0, level}, speed_detect_hysteresis);
  assign su_clear = sat_sub(lo_edge, speed_detect_hysteresis);
  always @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      at_speed_out <= 1'b0;
      speed_threshold_out <= 1'b0;
    end
    else if (I_DC_BRAKE)
    begin
      at_speed_out <= 1'b0;
      speed_threshold_out <= 1'b0;
    end
    else
    begin
      if ({1'b0, I_SPEED} >= {1'b0, level})
        speed_threshold_out <= 1'b1;
      else if ({1'b0, I_SPEED} < fu_clear)
        speed_threshold_out <= 1'b0;
      if ({1'b0, I_SPEED} >= lo_edge && {1'b0, I_SPEED} <= hi_edge)
        at_speed_out <= 1'b1;
      else if ({1'b0, I_SPEED} < su_clear ||
        {2'b00, I_SPEED} > {1'b0, hi_edge} + {8'h00, speed_detect_hysteresis})
        at_speed_out <= 1'b0;
    end
  end
  // ****************************************************************
  // Terminal routing
  // ****************************************************************
  assign flags = {speed_threshold_out, at_speed_out, internal_fault_out,
    fault_out, motion_active_out, preexcite_ready_brake_out,
    preexcite_ready_out, drive_ready_out};
  // Each terminal decodes its own code; no exclusivity between them
  always @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_TERMINAL_A <= 1'b0;
      O_TERMINAL_B <= 1'b0;
      O_TERMINAL_C <= 1'b0;
      O_FLAGS <= 8'h00;
    end
    else
    begin
      O_TERMINAL_A <= term_level(terminal_function_sel_a, flags);
      O_TERMINAL_B <= term_level(terminal_function_sel_b, flags);
      O_TERMINAL_C <= term_level(terminal_function_sel_c, flags);
      O_FLAGS <= flags;
    end
  end
endmodule // dso_top

// ===== tb/dso_chk_checker.sv
// Checker for dso_top: flag relations seen at its top ports.
// Assumes binding into dso_top; one clock, synchronous reset.
`timescale 1ns/1ps
module dso_chk
(
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire I_MAIN_POWER_OK,
  input wire I_OUTPUT_SHUTOFF_IN,
  input wire I_RUNNING,
  input wire I_ZERO_SPEED_CTRL,
  input wire I_SERVO_LOCK,
  input wire I_DC_BRAKE,
  input wire I_PREEXCITE_CMD_IN,
  input wire I_BRAKE_OPEN_REQUEST,
  input wire I_FAULT,
  input wire I_GROUND_FAULT_TRIP,
  input wire I_ACCEL_OVERCURRENT_TRIP,
  input wire [7:0] O_FLAGS
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  // Flags lag inputs by two edges, ready by three after supply returns, so causes are held four
  property p_shutoff;
    (I_OUTPUT_SHUTOFF_IN || I_FAULT)[*4] |-> O_FLAGS[3:0] == 4'h0;
  endproperty
  a_shutoff: assert property (p_shutoff)
    else $error("ready or motion flag high in shutoff");
  property p_power;
    (!I_MAIN_POWER_OK)[*4] |-> !O_FLAGS[0];
  endproperty
  a_power: assert property (p_power)
    else $error("ready high without main supply");
  property p_ready;
    (!I_RST && I_MAIN_POWER_OK && !I_OUTPUT_SHUTOFF_IN && !I_FAULT)[*4]
      |-> O_FLAGS[0];
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready low while able to run");
  property p_motion;
    (!I_RUNNING || I_ZERO_SPEED_CTRL || I_SERVO_LOCK || I_DC_BRAKE)[*4]
      |-> !O_FLAGS[3];
  endproperty
  a_motion: assert property (p_motion)
    else $error("motion flag high while stopped or held");
  property p_dc;
    I_DC_BRAKE[*4] |-> O_FLAGS[7:6] == 2'b00;
  endproperty
  a_dc: assert property (p_dc)
    else $error("speed flag high in DC braking");
  property p_dc_pre;
    (I_DC_BRAKE && I_MAIN_POWER_OK && !I_OUTPUT_SHUTOFF_IN && !I_FAULT)[*4]
      |-> O_FLAGS[1];
  endproperty
  a_dc_pre: assert property (p_dc_pre)
    else $error("pre-excitation flag low in DC braking");
  property p_brake;
    I_BRAKE_OPEN_REQUEST[*4] |-> !O_FLAGS[2];
  endproperty
  a_brake: assert property (p_brake)
    else $error("brake ready flag high in interlock");
  property p_fault;
    I_FAULT[*4] |-> O_FLAGS[4];
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault flag low during fault");
  property p_internal;
    (I_GROUND_FAULT_TRIP || I_ACCEL_OVERCURRENT_TRIP)[*4] |-> O_FLAGS[5];
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal fault flag low on wiring trip");
  property p_delay;
    ($rose(I_PREEXCITE_CMD_IN) && !I_DC_BRAKE && !O_FLAGS[1])
      ##1 (!I_DC_BRAKE)[*8] |-> !O_FLAGS[1];
  endproperty
  a_delay: assert property (p_delay)
    else $error("pre-excitation flag rose too early");
endmodule // dso_chk
bind dso_top dso_chk chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
  .I_MAIN_POWER_OK(I_MAIN_POWER_OK),
  .I_OUTPUT_SHUTOFF_IN(I_OUTPUT_SHUTOFF_IN), .I_RUNNING(I_RUNNING),
  .I_ZERO_SPEED_CTRL(I_ZERO_SPEED_CTRL), .I_SERVO_LOCK(I_SERVO_LOCK),
  .I_DC_BRAKE(I_DC_BRAKE), .I_PREEXCITE_CMD_IN(I_PREEXCITE_CMD_IN),
  .I_BRAKE_OPEN_REQUEST(I_BRAKE_OPEN_REQUEST), .I_FAULT(I_FAULT),
  .I_GROUND_FAULT_TRIP(I_GROUND_FAULT_TRIP),
  .I_ACCEL_OVERCURRENT_TRIP(I_ACCEL_OVERCURRENT_TRIP), .O_FLAGS(O_FLAGS));

// ===== tb/dso_equip.sv
// Model of the equipment reading the three output terminals.
// Assumes terminal levels synchronous to the core clock.
`timescale 1ns/1ps
module dso_equip
(
  input wire i_clk,
  input wire i_rst,
  input wire [2:0] i_term,
  output reg [2:0] o_seen,
  output reg [7:0] o_relay_toggles
);
  // ****************************************************************
  // Terminal sampling
  // ****************************************************************
  // Relay wear grows with switching, so its changes are counted
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_seen <= 3'h0;
      o_relay_toggles <= 8'h00;
    end
    else
    begin
      o_seen <= i_term;
      if (i_term[2] != o_seen[2])
        o_relay_toggles <= o_relay_toggles + 8'h01;
    end
  end
endmodule // dso_equip

// ===== tb/dso_top_tb_top.sv
// Testbench for dso_top: bus tasks, drive state stimulus, flag checks.
// Assumes a 40 MHz clock and the terminal reader dso_equip.
`timescale 1ns/1ps
module dso_top_tb_top;
  localparam [143:0] CODES = {8'hc8, 8'h05, 8'hc7, 8'h63, 8'hbf, 8'h5b,
    8'h89, 8'h25, 8'h85, 8'h21, 8'h6f, 8'h0b, 8'h68, 8'h04, 8'h65, 8'h01,
    8'h64, 8'h00};
  localparam [17:0] CEXP = 18'h0aa55;
  localparam [159:0] RV = {16'h0000, 16'h0000, 16'h0001, 16'h000f,
    16'h270f, 16'h00b4, 16'h000a, 16'h0063, 16'h000b, 16'h0000};
  localparam [263:0] SPT = {24'h1004b0, 24'h30041a, 24'h3003b6,
    24'h1002bc, 24'h1000fa, 24'h50012c, 24'h4000fa, 24'h0000a4,
    24'h1000a5, 24'h1000b4, 24'h0000b3};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [11:0] st = 12'h001;
  reg [6:0] trip = 7'h00;
  reg [13:0] spd = 14'h0000;
  reg rev = 1'b0;
  reg [13:0] sets = 14'h03e8;
  wire [31:0] hrdata;
  wire hrdy;
  wire hresp;
  wire [7:0] flags;
  wire [2:0] term;
  wire [2:0] seen;
  wire [7:0] toggles;
  integer err_count = 0;
  integer n_tests = 0;
  integer i;
  reg [31:0] rd;
  reg [23:0] e;
  always #12.5 clk = ~clk;
  dso_top dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hrdy),
    .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .I_MAIN_POWER_OK(st[0]), .I_OUTPUT_SHUTOFF_IN(st[1]),
    .I_RUNNING(st[2]), .I_ZERO_SPEED_CTRL(st[3]), .I_SERVO_LOCK(st[4]),
    .I_DC_BRAKE(st[5]), .I_PREEXCITE_CMD_IN(st[6]),
    .I_BRAKE_OPEN_REQUEST(st[7]), .I_PM_MODE(st[8]), .I_FAULT(st[9]),
    .I_FORWARD_START_IN(st[10]), .I_REVERSE_START_IN(st[11]),
    .I_GROUND_FAULT_TRIP(trip[0]), .I_ACCEL_OVERCURRENT_TRIP(trip[1]),
    .I_BRAKE_TRANSISTOR_TRIP(trip[2]), .I_PHASE_LOSS_TRIP(trip[3]),
    .I_PARAM_STORE_TRIP(trip[4]), .I_PROCESSOR_TRIP(trip[5]),
    .I_INRUSH_CIRCUIT_TRIP(trip[6]), .I_SPEED(spd),
    .I_SPEED_REVERSE(rev), .I_SET_SPEED(sets), .O_TERMINAL_A(term[0]),
    .O_TERMINAL_B(term[1]), .O_TERMINAL_C(term[2]), .O_FLAGS(flags));
  dso_equip equip_u (.i_clk(clk), .i_rst(rst), .i_term(term),
    .o_seen(seen), .o_relay_toggles(toggles));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task results;
  begin
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input [31:0] s, input [31:0] x);
  begin
    n_tests = n_tests + 1;
    if (s !== x)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  end
  endtask
  task wrdy;
    integer k;
  begin
    k = 0;
    @(posedge clk);
    while (hrdy !== 1'b1)
    begin
      k = k + 1;
      if (k > 50)
      begin
        err_count = err_count + 1;
        results;
      end
      @(posedge clk);
    end
  end
  endtask
  // Single word transfer; read data is taken at the data phase edge
  task xfer(input [7:0] a, input w, input [31:0] d);
  begin
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wrdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wrdy;
    rd = hrdata;
  end
  endtask
  task idle(input integer n);
  begin
    repeat (n) @(posedge clk);
  end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    idle(3);
    rst <= 1'b0;
    idle(2);
    for (i = 0; i < 10; i = i + 1)
    begin
      xfer(8'h04 * i[7:0], 1'b0, 32'h0);
      chk(rd, {16'h0, RV[i * 16 +: 16]});
    end
    chk({28'h0, hresp, seen}, 32'h2);
    xfer(8'h0c, 1'b1, 32'hc8);
    xfer(8'h18, 1'b1, 32'hc8);
    xfer(8'h0c, 1'b0, 32'h0);
    chk(rd, 32'h64);
    xfer(8'h18, 1'b0, 32'h0);
    chk(rd, 32'h96);
    xfer(8'h0c, 1'b1, 32'h0a);
    xfer(8'h18, 1'b1, 32'h0f);
    st[1] <= 1'b1;
    idle(5);
    chk({21'h0, flags, seen}, 32'h0);
    st <= 12'h000;
    idle(5);
    chk({24'h0, flags}, 32'h0);
    st <= 12'h201;
    idle(5);
    chk({21'h0, flags, seen}, 32'h84);
    // Inverted fault code 199 turns the relay terminal off
    xfer(8'h08, 1'b1, 32'hc7);
    idle(5);
    chk({29'h0, seen}, 32'h0);
    for (i = 0; i < 7; i = i + 1)
    begin
      trip <= 7'h01 << i;
      idle(5);
      chk({31'h0, flags[5]}, 32'h1);
    end
    trip <= 7'h00;
    st <= 12'h005;
    idle(5);
    chk({24'h0, flags}, 32'h01);
    spd <= 14'h0001;
    idle(5);
    chk({31'h0, flags[3]}, 32'h1);
    for (i = 3; i < 6; i = i + 1)
    begin
      st[i] <= 1'b1;
      idle(5);
      chk({31'h0, flags[3]}, 32'h0);
      st[i] <= 1'b0;
      idle(5);
    end
    spd <= 14'h00c8;
    sets <= 14'h00c8;
    for (i = 0; i < 18; i = i + 1)
    begin
      xfer(8'h00, 1'b1, {24'h0, CODES[i * 8 +: 8]});
      xfer(8'h04, 1'b1, {24'h0, CODES[i * 8 +: 8]});
      idle(5);
      chk({30'h0, seen[1:0]}, {30'h0, {2{CEXP[i]}}});
    end
    xfer(8'h00, 1'b1, 32'h0b);
    xfer(8'h04, 1'b1, 32'h6f);
    idle(5);
    chk({30'h0, seen[1:0]}, 32'h1);
    xfer(8'h00, 1'b1, 32'h69);
    idle(5);
    chk({31'h0, seen[0]}, 32'h0);
    sets <= 14'h03e8;
    spd <= 14'h0000;
    xfer(8'h14, 1'b1, 32'h12c);
    for (i = 0; i < 11; i = i + 1)
    begin
      e = SPT[i * 24 +: 24];
      rev <= e[22];
      spd <= e[13:0];
      idle(5);
      chk({30'h0, flags[6], flags[7]}, {30'h0, e[21:20]});
    end
    st[5] <= 1'b1;
    idle(5);
    chk({24'h0, flags}, 32'h07);
    st[7] <= 1'b1;
    idle(5);
    chk({24'h0, flags}, 32'h03);
    st <= 12'h001;
    spd <= 14'h0000;
    idle(5);
    st[6] <= 1'b1;
    idle(1000);
    chk({30'h0, flags[2:1]}, 32'h0);
    xfer(8'h20, 1'b1, 32'h5);
    st <= 12'h505;
    spd <= 14'h00c8;
    idle(1000);
    chk({31'h0, flags[3]}, 32'h0);
    chk({24'h0, toggles}, 32'h3);
    results;
  end
endmodule // dso_top_tb_top
